// [kvp_panel.sv]
/*
  kvp_panel: front-panel value entry, display and indicator logic.
  Assumes key inputs are already debounced pins, synchronised here, and that
  software loads the shown value and limits over the AHB-Lite slave.
*/
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns

module kvp_panel
  import kvp_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // keypad pins
  input  wire kvp_pkg::kvp_keys_t   keys,
  // pump side
  input  wire logic                 host_rate_write,
  input  wire logic                 phase_end,
  output kvp_pkg::kvp_disp_t        disp,
  output logic      [7:0]           leds,
  output kvp_pkg::kvp_commit_t      commit,
  output logic                      restart_phase1
);
  import kvp_pkg::*;

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [3:0] bcd_inc(input logic [3:0] d);
    bcd_inc = (d == 4'h9) ? 4'h0 : 4'(d + 4'h1);
  endfunction : bcd_inc

  function automatic logic [3:0] dp_onehot(input logic [1:0] pos);
    // the right-most position stays dark: whole number
    dp_onehot = (pos == 2'h3) ? 4'h0 : 4'(4'h8 >> pos);
  endfunction : dp_onehot

  // ==========================================================================
  // key synchronisers and edges
  // ==========================================================================
  kvp_keys_t key_meta;
  kvp_keys_t key_sync;
  kvp_keys_t key_prev;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      key_meta <= '0;
      key_sync <= '0;
      key_prev <= '0;
    end
    else
    begin
      key_meta <= keys;
      key_sync <= key_meta;
      key_prev <= key_sync;
    end
  end

  logic [3:0] arrow_rise;
  logic       func_rise;
  logic       start_rise;
  logic       any_rise;
  assign arrow_rise = key_sync.arrow & ~key_prev.arrow;
  assign func_rise  = key_sync.func  & ~key_prev.func;
  assign start_rise = key_sync.start & ~key_prev.start;
  assign any_rise   = (|arrow_rise) | func_rise | start_rise;

  // ==========================================================================
  // registers
  // ==========================================================================
  logic [31:0] ctrl;
  logic [15:0] shown;
  logic [1:0]  shown_dp;
  logic [15:0] limit;
  logic [31:0] next_ctrl;
  logic [15:0] next_limit;
  logic        ph_write;
  logic [7:0]  ph_addr;
  logic        load_shown;

  kvp_pump_t pump;
  kvp_mode_t mode;
  logic [2:0] unit_sel;
  logic [3:0] list_max;
  assign pump     = kvp_pump_t'(ctrl[CTRL_RUN_BIT+1 -: 2]);
  assign mode     = kvp_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
  assign list_max = ctrl[CTRL_LISTMAX_LSB +: 4];

  // ==========================================================================
  // edit state machine
  // ==========================================================================
  typedef enum logic [1:0] { ST_SHOW, ST_EDIT, ST_ERROR } kvp_state_t;

  kvp_state_t  state;
  kvp_state_t  next_state;
  logic [15:0] edit;
  logic [15:0] next_edit;
  logic [1:0]  edit_dp;
  logic [1:0]  next_edit_dp;
  logic [2:0]  edit_unit;
  logic [2:0]  next_edit_unit;
  logic [24:0] idle_cnt;
  logic [24:0] next_idle_cnt;
  logic [24:0] hold_cnt;
  logic [24:0] next_hold_cnt;
  logic [24:0] rep_cnt;
  logic [24:0] next_rep_cnt;
  logic        blink_req;
  logic        next_blink_req;
  logic        do_commit;
  logic [3:0]  step;
  logic        held_long;
  logic        dp_walk;
  logic        next_dp_walk;

  // held-key repeat: first step on the press, then one per repeat period
  assign held_long = (hold_cnt >= 25'(HOLD_CYCLES));
  always_comb
  begin
    step = arrow_rise;
    if (rep_cnt == 25'(REPEAT_CYCLES - 1))
      step = step | key_sync.arrow;
  end

  always_comb
  begin
    next_state     = state;
    next_edit      = edit;
    next_edit_dp   = edit_dp;
    next_edit_unit = edit_unit;
    next_idle_cnt  = idle_cnt;
    next_hold_cnt  = key_sync.arrow[3] ? 25'(hold_cnt + ((held_long) ? 25'h0 : 25'h1)) : 25'h0;
    next_rep_cnt   = (|key_sync.arrow && rep_cnt != 25'(REPEAT_CYCLES - 1)) ? 25'(rep_cnt + 25'h1) : 25'h0;
    next_blink_req = 1'b0;
    do_commit      = 1'b0;
    next_dp_walk   = dp_walk && key_sync.arrow[3]; // releasing the left key ends the walk
    unique case (state)
      ST_SHOW:
      begin
        // a function key only redisplays the current value
        next_edit      = shown;
        next_edit_dp   = shown_dp;
        next_edit_unit = unit_sel;
        if (|step)
        begin
          next_state    = ST_EDIT;
          next_idle_cnt = 25'h0;
        end
      end
      ST_EDIT:
      begin
        next_idle_cnt = 25'(idle_cnt + 25'h1);
        if (func_rise | start_rise | (idle_cnt == 25'(COMMIT_CYCLES - 1)))
        begin
          do_commit  = 1'b1;
          next_state = ST_SHOW;
        end
        else if (|step)
          next_idle_cnt = 25'h0;
      end
      ST_ERROR:
      begin
        // any key clears the message; shown was never overwritten
        if (any_rise)
          next_state = ST_SHOW;
      end
    endcase

    // apply steps to the edit copy (first step also, from show state)
    if (state != ST_ERROR && |step)
    begin
      if (state == ST_SHOW)
      begin
        next_edit    = shown;
        next_edit_dp = shown_dp;
      end
      unique case (mode)
        KVP_MODE_UNITS:
          next_edit_unit = (edit_unit == 3'(N_UNITS - 1)) ? 3'h0 : 3'(edit_unit + 3'h1);
        KVP_MODE_LIST:
          next_edit[3:0] = (edit[3:0] >= list_max) ? 4'h0 : 4'(edit[3:0] + 4'h1);
        default:
        begin
          // adjacent pairs toggle the point between them
          if (arrow_rise != 4'h0 && $countones(key_sync.arrow) == 2)
          begin
            for (int i = 0; i < 3; i++)
              if (key_sync.arrow[3-i] && key_sync.arrow[2-i])
                next_edit_dp = (edit_dp == 2'(i)) ? 2'h3 : 2'(i);
          end
          else
          begin
            for (int i = 0; i < 4; i++)
              if (step[i] && !(i == 3 && dp_walk))
                next_edit[i*4 +: 4] = bcd_inc(next_edit[i*4 +: 4]);
            // left key held: once its digit has wrapped, every further step walks the point
            if (step[3] && dp_walk)
              next_edit_dp = 2'(next_edit_dp + 2'h1);
            else if (step[3] && held_long && next_edit[15:12] == 4'h0)
              next_dp_walk = 1'b1;
          end
        end
      endcase
    end

    if (do_commit)
    begin
      if (edit > limit)
        next_state = ST_ERROR;
      else
        next_blink_req = (edit != shown) || (edit_dp != shown_dp) || (edit_unit != unit_sel);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state     <= ST_SHOW;
      edit      <= VALUE_RESET;
      edit_dp   <= DP_RESET;
      edit_unit <= 3'h0;
      idle_cnt  <= 25'h0;
      hold_cnt  <= 25'h0;
      rep_cnt   <= 25'h0;
      blink_req <= 1'b0;
      dp_walk   <= 1'b0;
    end
    else
    begin
      dp_walk   <= next_dp_walk;
      state     <= next_state;
      edit      <= next_edit;
      edit_dp   <= next_edit_dp;
      edit_unit <= next_edit_unit;
      idle_cnt  <= next_idle_cnt;
      hold_cnt  <= next_hold_cnt;
      rep_cnt   <= next_rep_cnt;
      blink_req <= next_blink_req;
    end
  end

  logic commit_ok;
  assign commit_ok = do_commit && !(edit > limit);

  // ==========================================================================
  // shown value, unit, commit output
  // ==========================================================================
  logic [15:0]  next_shown;
  logic [1:0]   next_shown_dp;
  logic [2:0]   next_unit_sel;
  kvp_commit_t  next_commit;

  always_comb
  begin
    next_shown    = shown;
    next_shown_dp = shown_dp;
    next_unit_sel = unit_sel;
    next_commit   = '0;
    if (commit_ok)
    begin
      next_shown          = edit;
      next_shown_dp       = edit_dp;
      next_unit_sel       = edit_unit;
      next_commit.strobe  = 1'b1;
      next_commit.save_nv = 1'b1;
      next_commit.value   = edit;
      next_commit.dp      = edit_dp;
    end
    else if (load_shown)
    begin
      next_shown         = hwdata[15:0];
      next_shown_dp      = hwdata[17:16];
      next_commit.strobe = ctrl[CTRL_HOSTR_BIT];
      // host rate change during a run is applied but not stored
      next_commit.save_nv = !(host_rate_write && pump == KVP_PUMP_RUNNING);
      next_commit.value   = hwdata[15:0];
      next_commit.dp      = hwdata[17:16];
    end
    if (ph_write && ph_addr == REG_CTRL)
      next_unit_sel = hwdata[CTRL_UNIT_LSB +: 3];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      shown    <= VALUE_RESET;
      shown_dp <= DP_RESET;
      unit_sel <= 3'h0;
      commit   <= '0;
    end
    else
    begin
      shown    <= next_shown;
      shown_dp <= next_shown_dp;
      unit_sel <= next_unit_sel;
      commit   <= next_commit;
    end
  end

  // ==========================================================================
  // blink timers and start/stop
  // ==========================================================================
  logic [21:0] blink_cnt;
  logic        blink_phase;
  logic [3:0]  flash_left;
  logic [21:0] next_blink_cnt;
  logic        next_blink_phase;
  logic [3:0]  next_flash_left;
  logic        next_restart;

  always_comb
  begin
    next_blink_cnt   = (blink_cnt == 22'(BLINK_CYCLES - 1)) ? 22'h0 : 22'(blink_cnt + 22'h1);
    next_blink_phase = (blink_cnt == 22'(BLINK_CYCLES - 1)) ? ~blink_phase : blink_phase;
    next_flash_left  = flash_left;
    if (blink_req)
      next_flash_left = 4'h4;
    else if (blink_cnt == 22'(BLINK_CYCLES - 1) && flash_left != 4'h0)
      next_flash_left = 4'(flash_left - 4'h1);
    // start from a full stop begins again at phase 1; paused resumes
    next_restart = start_rise && (pump == KVP_PUMP_STOPPED);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      blink_cnt      <= 22'h0;
      blink_phase    <= 1'b0;
      flash_left     <= 4'h0;
      restart_phase1 <= 1'b0;
    end
    else
    begin
      blink_cnt      <= next_blink_cnt;
      blink_phase    <= next_blink_phase;
      flash_left     <= next_flash_left;
      restart_phase1 <= next_restart;
    end
  end

  // ==========================================================================
  // display and leds
  // ==========================================================================
  logic [4:0] unit_leds;
  logic [2:0] unit_now;
  assign unit_now = (state == ST_SHOW) ? unit_sel : edit_unit;

  // leds 0..4: mm, ml, ul, min, hr; rates light a pair
  always_comb
  begin
    unique case (unit_now)
      3'h0:    unit_leds = 5'b00001;
      3'h1:    unit_leds = 5'b00010;
      3'h2:    unit_leds = 5'b01010;
      3'h3:    unit_leds = 5'b10010;
      3'h4:    unit_leds = 5'b01100;
      3'h5:    unit_leds = 5'b10100;
      default: unit_leds = 5'b00000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      disp <= '0;
      leds <= 8'h00;
    end
    else
    begin
      disp.digits   <= (state == ST_SHOW) ? shown : edit;
      disp.dp       <= dp_onehot((state == ST_SHOW) ? shown_dp : edit_dp);
      disp.colon    <= ctrl[CTRL_COLON_BIT];
      disp.triangle <= ctrl[CTRL_RXOK_BIT];
      disp.error    <= (state == ST_ERROR);
      disp.blank    <= (flash_left != 4'h0) && blink_phase;
      leds[4:0]     <= (state == ST_EDIT && blink_phase) ? 5'h00 : unit_leds;
      leds[5]       <= ctrl[CTRL_DISP_BIT];
      leds[6]       <= ctrl[CTRL_DIR_BIT];
      leds[7]       <= (pump == KVP_PUMP_RUNNING) ||
                       (pump == KVP_PUMP_PAUSED && blink_phase);
    end
  end

  // ==========================================================================
  // ahb-lite slave, zero wait states
  // ==========================================================================
  logic [31:0] next_hrdata;

  always_comb
  begin
    next_ctrl  = ctrl;
    next_limit = limit;
    load_shown = 1'b0;
    if (ph_write)
      unique case (ph_addr)
        REG_CTRL:  next_ctrl  = hwdata;
        REG_LIMIT: next_limit = hwdata[15:0];
        REG_VALUE: load_shown = 1'b1;
        default:   ;
      endcase
    // a finished phase with nothing left ends the run
    if (phase_end)
      next_ctrl[CTRL_RUN_BIT+1 -: 2] = 2'(KVP_PUMP_STOPPED);
    unique case (haddr)
      REG_CTRL:   next_hrdata = ctrl;
      REG_VALUE:  next_hrdata = {14'h0, shown_dp, shown};
      REG_LIMIT:  next_hrdata = {16'h0, limit};
      REG_STATUS: next_hrdata = {24'h0, leds[7:6], 1'b0, unit_sel, state};
      REG_COMMIT: next_hrdata = {14'h0, commit.dp, commit.value};
      REG_LED:    next_hrdata = {24'h0, leds};
      default:    next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl     <= CTRL_RESET;
      limit    <= LIMIT_RESET;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end
    else
    begin
      ctrl     <= next_ctrl;
      limit    <= next_limit;
      ph_write <= hsel && hready && htrans[1] && hwrite;
      ph_addr  <= haddr;
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata <= next_hrdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================================
  // checks
  // ==========================================================================
  a_commit_timeout: assert property (@(posedge clock) disable iff (rst)
    (state == ST_EDIT && idle_cnt == 25'(COMMIT_CYCLES - 1) && !(|step)) |=> state != ST_EDIT)
    else $error("edit did not end at timeout");
  a_error_clears: assert property (@(posedge clock) disable iff (rst)
    (state == ST_ERROR && any_rise) |=> (state == ST_SHOW && $stable(shown)))
    else $error("error not cleared by key");
  a_blink_valid: assert property (@(posedge clock) disable iff (rst)
    blink_req |-> $past(do_commit) && !$past(edit > limit))
    else $error("blink without valid commit");
  a_right_dp_dark: assert property (@(posedge clock) disable iff (rst)
    disp.dp[0] == 1'b0)
    else $error("right-most point lit");
  a_pump_led: assert property (@(posedge clock) disable iff (rst)
    (pump == KVP_PUMP_RUNNING) ##1 (pump == KVP_PUMP_RUNNING) |-> leds[7])
    else $error("pumping led off while running");
  a_digit_wrap: assert property (@(posedge clock) disable iff (rst)
    (state == ST_EDIT && mode == KVP_MODE_DIGITS && step == 4'h1 && edit[3:0] == 4'h9) |=> edit[3:0] == 4'h0)
    else $error("digit did not wrap");
  a_restart_stop: assert property (@(posedge clock) disable iff (rst)
    restart_phase1 |-> $past(start_rise) && $past(pump) == KVP_PUMP_STOPPED)
    else $error("restart when not stopped");
  a_unit_wrap: assert property (@(posedge clock) disable iff (rst)
    (state == ST_EDIT && mode == KVP_MODE_UNITS && |step && edit_unit == 3'(N_UNITS - 1)) |=> edit_unit == 3'h0)
    else $error("unit did not wrap");

endmodule : kvp_panel

// [kvp_pkg.sv]
/*
  kvp_pkg: constants, register map, types and states for the keypad value
  entry panel.
  Assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package kvp_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned COMMIT_MS      = 2000;
  localparam int unsigned HOLD_MS        = 1000;
  localparam int unsigned REPEAT_MS      = 200;
  localparam int unsigned BLINK_MS       = 250;
  localparam int unsigned COMMIT_CYCLES  = CLK_HZ / 1000 * COMMIT_MS;
  localparam int unsigned HOLD_CYCLES    = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned REPEAT_CYCLES  = CLK_HZ / 1000 * REPEAT_MS;
  localparam int unsigned BLINK_CYCLES   = CLK_HZ / 1000 * BLINK_MS;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_VALUE   = 8'h04;
  localparam logic [7:0] REG_LIMIT   = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic [7:0] REG_COMMIT  = 8'h10;
  localparam logic [7:0] REG_LED     = 8'h14;

  // control field positions
  localparam int unsigned CTRL_RUN_BIT     = 0;
  localparam int unsigned CTRL_DIR_BIT     = 5;
  localparam int unsigned CTRL_DISP_BIT    = 2;
  localparam int unsigned CTRL_RXOK_BIT    = 3;
  localparam int unsigned CTRL_COLON_BIT   = 4;
  localparam int unsigned CTRL_UNIT_LSB    = 8;
  localparam int unsigned CTRL_MODE_LSB    = 12;
  localparam int unsigned CTRL_LISTMAX_LSB = 16;
  localparam int unsigned CTRL_HOSTR_BIT   = 20;

  // reset values
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [1:0]  DP_RESET    = 2'h3;
  localparam logic [15:0] LIMIT_RESET = 16'h9999;

  // ==========================================================================
  // key codes
  // ==========================================================================
  localparam int unsigned N_DIGITS = 4;
  localparam int unsigned N_UNITS  = 6;

  // edit modes chosen by software for the value on show
  typedef enum logic [1:0] {
    KVP_MODE_DIGITS,
    KVP_MODE_LIST,
    KVP_MODE_UNITS
  } kvp_mode_t;

  // pump program state reported to the panel
  typedef enum logic [1:0] {
    KVP_PUMP_STOPPED,
    KVP_PUMP_RUNNING,
    KVP_PUMP_PAUSED
  } kvp_pump_t;

  // keypad inputs: four arrows, one function key and start/stop
  typedef struct packed {
    logic [3:0] arrow;
    logic       func;
    logic       start;
  } kvp_keys_t;

  // display drive
  typedef struct packed {
    logic [15:0] digits;
    logic [3:0]  dp;
    logic        colon;
    logic        triangle;
    logic        error;
    logic        blank;
  } kvp_disp_t;

  // commit event to the rest of the pump
  typedef struct packed {
    logic        strobe;
    logic        save_nv;
    logic [15:0] value;
    logic [1:0]  dp;
  } kvp_commit_t;

endpackage : kvp_pkg

// [kvp_operator.sv]
/*
  kvp_operator: behavioural front-panel operator who presses keypad keys.
  Assumes the bench calls press() and that a released key reads low.
*/
`timescale 1ns/1ns

module kvp_operator
  import kvp_pkg::*;
(
  // clock
  input  wire logic          clock,
  // keypad pins
  output kvp_pkg::kvp_keys_t keys
);
  initial keys = '0;

  // ==========================================================================
  // key presses
  // ==========================================================================
  // short press, well below the hold time, so no repeat or point shift
  task press(input logic [5:0] k);
    @(posedge clock);
    keys <= k;
    repeat (4) @(posedge clock);
    keys <= '0;
    repeat (8) @(posedge clock);
  endtask : press
endmodule : kvp_operator

// [keypad_value_entry_panel_tb.sv]
/*
  keypad_value_entry_panel_tb: self-checking bench for the panel.
  Assumes the single ahb-lite slave is zero-wait and keys come from the operator.
*/
`timescale 1ns/1ns

module keypad_value_entry_panel_tb;
  import kvp_pkg::*;
  logic               clock, rst, hsel, hwrite, host_rate_write, phase_end;
  logic               hreadyout, hresp, restart_phase1;
  logic [7:0]         haddr, leds;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        hwdata, hrdata, d;
  kvp_keys_t          keys;
  kvp_disp_t          disp;
  kvp_commit_t        commit, got_commit;
  int                 bad_count, cmp_count, strobes, restarts, cyc;

  kvp_panel DUT (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .keys(keys), .host_rate_write(host_rate_write),
    .phase_end(phase_end), .disp(disp), .leds(leds), .commit(commit),
    .restart_phase1(restart_phase1));
  kvp_operator op (.clock(clock), .keys(keys));

  // ==========================================================================
  // clock, pulse capture and timeout
  // ==========================================================================
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // one-cycle pulses are caught here so tests can look later
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (commit.strobe === 1'b1)
    begin
      got_commit <= commit;
      strobes    <= strobes + 1;
    end
    if (restart_phase1 === 1'b1)
      restarts <= restarts + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  task finish_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task check(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check

  // single ahb-lite transfer; waits on hready, read data taken at data end
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    d = hrdata;
    repeat (4) @(posedge clock);
  endtask : bus

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    {rst, hsel, haddr, htrans, hwrite, hwdata} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    {host_rate_write, phase_end, bad_count, cmp_count, strobes, restarts, cyc} = '0;
    got_commit = '0;
    repeat (20) @(posedge clock);
    check("disp", 32'h0000_0000, disp);
    check("hreadyout", 32'h0000_0001, hreadyout);
    check("hresp", 32'h0000_0000, hresp);
    rst <= 1'b0;
    bus(1'b0, REG_LIMIT, '0);
    check("limit", {16'h0000, LIMIT_RESET}, d);
    bus(1'b0, 8'h20, '0);
    check("unmapped", 32'h0000_0000, d);
    bus(1'b1, REG_VALUE, 32'h0003_1239);
    check("digits", 32'h0000_1239, disp.digits);
    check("dp", 32'h0000_0000, disp.dp);
    op.press(6'b0001_00);
    check("digits", 32'h0000_1230, disp.digits);
    op.press(6'b0000_10);
    check("strobes", 32'h0000_0001, strobes);
    check("value", 32'h0000_1230, got_commit.value);
    check("save_nv", 32'h0000_0001, got_commit.save_nv);
    // left digit past the limit makes the commit invalid
    bus(1'b1, REG_LIMIT, 32'h0000_1000);
    op.press(6'b1000_00);
    op.press(6'b0000_10);
    check("error", 32'h0000_0001, disp.error);
    op.press(6'b0000_10);
    check("error", 32'h0000_0000, disp.error);
    check("digits", 32'h0000_1230, disp.digits);
    op.press(6'b0011_00);
    check("dp", 32'h0000_0002, disp.dp);
    check("digits", 32'h0000_1230, disp.digits);
    // running, dispensed shown, triangle and colon lit
    bus(1'b1, REG_CTRL, 32'h0000_001D);
    check("leds", 32'h0000_0005, leds[7:5]);
    check("segs", 32'h0000_0003, {disp.colon, disp.triangle});
    bus(1'b1, REG_CTRL, 32'h0000_0020);
    check("withdraw", 32'h0000_0001, leds[6]);
    bus(1'b1, REG_CTRL, 32'h0000_0000);
    check("leds", 32'h0000_0000, leds[7:5]);
    op.press(6'b0000_01);
    check("restarts", 32'h0000_0001, restarts);
    // start also commits the over-limit edit; the next key clears the error
    check("error", 32'h0000_0001, disp.error);
    op.press(6'b0000_10);
    bus(1'b1, REG_LIMIT, 32'h0000_9999);
    // unit selection: any arrow steps to the next unit
    bus(1'b1, REG_CTRL, 32'h0000_2000);
    op.press(6'b0100_00);
    check("units", 32'h0000_0002, leds[4:0]);
    op.press(6'b0000_10);
    check("strobes", 32'h0000_0002, strobes);
    check("units", 32'h0000_0002, leds[4:0]);
    // list setting with maximum 1: 0, 1, then back to 0
    bus(1'b1, REG_CTRL, 32'h0001_1000);
    op.press(6'b0001_00);
    check("list", 32'h0000_1231, disp.digits);
    op.press(6'b0001_00);
    check("list", 32'h0000_1230, disp.digits);
    op.press(6'b0000_10);
    // host value write while running is applied but not stored
    host_rate_write <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h0010_0001);
    bus(1'b1, REG_VALUE, 32'h0003_0042);
    check("value", 32'h0000_0042, got_commit.value);
    check("save_nv", 32'h0000_0000, got_commit.save_nv);
    host_rate_write <= 1'b0;
    phase_end       <= 1'b1;
    @(posedge clock);
    phase_end <= 1'b0;
    repeat (2) @(posedge clock);
    check("pumping", 32'h0000_0000, leds[7]);
    op.press(6'b0000_01);
    check("restarts", 32'h0000_0002, restarts);
    // a paused program resumes: no restart
    bus(1'b1, REG_CTRL, 32'h0000_0002);
    op.press(6'b0000_01);
    check("restarts", 32'h0000_0002, restarts);
    finish_test();
  end
endmodule : keypad_value_entry_panel_tb
